/* pcg_defines.svh */
// Purpose: constants of the packet controlled gpio port
// Assumes: 40 MHz sys_clk
// Notes: offsets are byte addresses on the register bus
`ifndef PCG_DEFINES_SVH
`define PCG_DEFINES_SVH
////////////////////////////////////////////////////////////////////////////////
// timing
`define PCG_CLK_MHZ 40
`define PCG_PWM_STEP_NS 100000
`define PCG_PWM_STEP_CYCLES ((`PCG_PWM_STEP_NS * `PCG_CLK_MHZ) / 1000)
`define PCG_PWM_STEPS 8'h64
`define PCG_PWM_LAST 8'h63
`define PCG_SAMPLE_NS 31250000
`define PCG_SAMPLE_CYCLES ((`PCG_SAMPLE_NS * `PCG_CLK_MHZ) / 1000)
////////////////////////////////////////////////////////////////////////////////
// command codes and replies
`define PCG_CMD_SET 8'h22
`define PCG_CMD_READ 8'h23
`define PCG_CMD_STORE 8'h04
`define PCG_REPLY_ACK 8'h40
`define PCG_REPLY_ERR 8'hC0
`define PCG_LEVEL_HIGH 8'h64
`define PCG_LEN_SET_VALUE 2'h2
`define PCG_LEN_SET_CFG 2'h3
`define PCG_LEN_READ 2'h1
`define PCG_LEN_STORE 2'h0
`define PCG_RLEN_READ 3'h4
`define PCG_RLEN_NONE 3'h0
////////////////////////////////////////////////////////////////////////////////
// register map
`define PCG_REG_CMD 8'h00
`define PCG_REG_GO 8'h04
`define PCG_REG_REPLY 8'h08
`define PCG_REG_RINFO 8'h0C
`define PCG_REG_PINS 8'h10
`define PCG_RESP_OKAY 2'h0
`define PCG_RESP_SLVERR 2'h2
////////////////////////////////////////////////////////////////////////////////
// factory configuration, pin 4 down to pin 0
`define PCG_FACTORY_DRIVE 15'h749A
`define PCG_FACTORY_FUNC 5'h00
`endif

/* pcg_pkg.sv */
// Purpose: types of the packet controlled gpio port
// Assumes: used with pcg_defines.svh
// Notes: nothing is imported, every use is scoped
package pcg_pkg;
	typedef enum logic [2:0] {
		DRV_UP_PULLDN = 3'b000,
		DRV_STRONG = 3'b001,
		DRV_HIZ = 3'b010,
		DRV_PULLUP_DN = 3'b011,
		DRV_SLOW_UP_HIZ = 3'b100,
		DRV_SLOW = 3'b101,
		DRV_RSVD = 3'b110,
		DRV_HIZ_SLOW_DN = 3'b111
	} pcg_drive_t;
	typedef struct packed {
		logic func;
		pcg_drive_t drive_mode;
		logic [7:0] level;
	} pcg_pin_cfg_t;
	typedef struct packed {
		logic [7:0] cfg;
		logic [7:0] value;
		logic [7:0] index;
		logic [7:0] code;
	} pcg_cmd_t;
	typedef struct packed {
		logic drive;
		logic pull_up;
		logic pull_dn;
		logic slow;
	} pcg_pad_t;
	typedef enum logic [0:0] {
		ST_RESTORE = 1'b0,
		ST_RUN = 1'b1
	} pcg_state_t;
endpackage : pcg_pkg

/* pcg_gpio_port.sv */
// Purpose: five pin gpio port driven by set, read and store commands over AXI4-Lite
// Assumes: 40 MHz sys_clk, rst soft reset, por power-on reset of the boot copy
// Notes: a command is loaded into CMD, then started by writing its length to GO
`include "pcg_defines.svh"
module pcg_gpio_port #(
	parameter int PINS = 5,
	parameter int ADDR_W = 8,
	parameter int SAMPLE_CYCLES = `PCG_SAMPLE_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic por,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [PINS-1:0] gpio_in,
	output logic [PINS-1:0] gpio_out,
	output logic [PINS-1:0] gpio_oe_n,
	output logic [PINS-1:0] gpio_pull_up,
	output logic [PINS-1:0] gpio_pull_dn,
	output logic [PINS-1:0] gpio_slow,
	input wire logic host_power_ctl,
	input wire logic host_reset_ctl,
	input wire logic one_wire_sensor_role_tx,
	output logic host_power_sense,
	output logic one_wire_sensor_role_rx
);
	localparam int STEP_CYCLES = `PCG_PWM_STEP_CYCLES;
	localparam int SCNT_W = $clog2(SAMPLE_CYCLES);
	localparam int PCNT_W = $clog2(STEP_CYCLES);
	localparam logic [SCNT_W-1:0] SAMPLE_LAST = SCNT_W'(SAMPLE_CYCLES - 1);
	localparam logic [PCNT_W-1:0] STEP_LAST = PCNT_W'(STEP_CYCLES - 1);

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	pcg_pkg::pcg_state_t state;
	pcg_pkg::pcg_cmd_t cmd_q;
	pcg_pkg::pcg_pin_cfg_t cfg_q [PINS];
	pcg_pkg::pcg_pin_cfg_t boot_q [PINS];
	logic aw_held, w_held, wr_do, go_pulse, wr_hit;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [1:0] go_len, start_len;
	logic idx_ok, val_ok, is_set, is_read, is_store, cmd_ok;
	logic [2:0] idx;
	logic [7:0] reply_type;
	logic [2:0] reply_len;
	logic [31:0] reply_data;
	logic [PINS-1:0] sync1, sync2, sync3, stab, pin_level, rise, fall, clr, role_level, pwm_high;
	logic [SCNT_W-1:0] sample_cnt;
	logic sample_tick, sample_seen;
	logic [PCNT_W-1:0] step_div;
	logic step_tick;
	logic [7:0] step_cnt;

	////////////////////////////////////////////////////////////////////////////////
	// write channel: address and data taken in either order, answer after both
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign wr_do = aw_held && w_held && !s_axi_bvalid;
	assign wr_hit = (aw_addr == `PCG_REG_CMD) || (aw_addr == `PCG_REG_GO);
	assign go_pulse = wr_do && (aw_addr == `PCG_REG_GO) && w_strb[0];
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_do) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
			end
		end
	end

	// write response, slverr on an unmapped or read-only word
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `PCG_RESP_OKAY;
		end else if (wr_do) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? `PCG_RESP_OKAY : `PCG_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// command word, byte lanes honoured
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cmd_q <= '0;
			go_len <= '0;
		end else if (wr_do && aw_addr == `PCG_REG_CMD) begin
			for (int b = 0; b < 4; b++) begin
				if (w_strb[b])
					cmd_q[b*8 +: 8] <= w_data[b*8 +: 8];
			end
		end else if (go_pulse) begin
			go_len <= w_data[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read channel: one cycle to rvalid, held until rready
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= `PCG_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `PCG_RESP_OKAY;
			unique case (s_axi_araddr)
				`PCG_REG_CMD: s_axi_rdata <= cmd_q;
				`PCG_REG_GO: s_axi_rdata <= {30'h0, go_len};
				`PCG_REG_REPLY: s_axi_rdata <= reply_data;
				`PCG_REG_RINFO: s_axi_rdata <= {21'h0, reply_len, reply_type};
				`PCG_REG_PINS: s_axi_rdata <= {17'h0, rise, fall, pin_level};
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= `PCG_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// command decode
	assign idx = cmd_q.index[2:0];
	assign idx_ok = cmd_q.index < 8'(PINS);
	assign val_ok = cmd_q.value <= `PCG_LEVEL_HIGH;
	// length comes straight from the go word, go_len only updates at the same edge
	assign start_len = w_data[1:0];
	assign is_set = go_pulse && cmd_q.code == `PCG_CMD_SET && idx_ok && val_ok
		&& (start_len == `PCG_LEN_SET_VALUE || start_len == `PCG_LEN_SET_CFG);
	assign is_read = go_pulse && cmd_q.code == `PCG_CMD_READ && idx_ok && start_len == `PCG_LEN_READ;
	assign is_store = go_pulse && cmd_q.code == `PCG_CMD_STORE && start_len == `PCG_LEN_STORE;
	assign cmd_ok = is_set || is_read || is_store;

	// reply: ack type is code with 0x40, refused commands get code with 0xC0
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reply_type <= '0;
			reply_len <= `PCG_RLEN_NONE;
			reply_data <= '0;
		end else if (go_pulse) begin
			reply_type <= (cmd_ok ? `PCG_REPLY_ACK : `PCG_REPLY_ERR) | cmd_q.code;
			reply_len <= is_read ? `PCG_RLEN_READ : `PCG_RLEN_NONE;
			reply_data <= '0;
			if (is_read)
				reply_data <= {4'h0, cfg_q[idx].func, cfg_q[idx].drive_mode, cfg_q[idx].level,
					5'h00, rise[idx], fall[idx], pin_level[idx], cmd_q.index};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// boot copy restored one cycle after reset release
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			state <= pcg_pkg::ST_RESTORE;
		else
			state <= pcg_pkg::ST_RUN;
	end

	////////////////////////////////////////////////////////////////////////////////
	// pwm time base: 100 steps of 100 us make the 10 ms period
	assign step_tick = step_div == STEP_LAST;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			step_div <= '0;
			step_cnt <= '0;
		end else if (step_tick) begin
			step_div <= '0;
			step_cnt <= (step_cnt == `PCG_PWM_LAST) ? 8'h00 : step_cnt + 8'h01;
		end else begin
			step_div <= step_div + PCNT_W'(1);
		end
	end
	a_pwm_wrap: assert property (step_tick && step_cnt == `PCG_PWM_LAST |=> step_cnt == 8'h00)
		else $error("pwm step count did not wrap after 100 steps");

	// 32 Hz sample strobe, free running
	assign sample_tick = sample_cnt == SAMPLE_LAST;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			sample_cnt <= '0;
		else
			sample_cnt <= sample_tick ? '0 : sample_cnt + SCNT_W'(1);
	end

	// first sample after reset only loads the level, so no false edge follows reset
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			sample_seen <= 1'b0;
		else if (sample_tick)
			sample_seen <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// default roles: pin 1 sense, 2 power, 3 reset, 4 one-wire
	assign role_level = {one_wire_sensor_role_tx, host_reset_ctl, host_power_ctl, 1'b1, 1'b0};
	assign host_power_sense = pin_level[1];
	assign one_wire_sensor_role_rx = stab[4];
	assign clr = is_read ? (PINS'(1) << idx) : '0;

	sequence s_set_ok;
		is_set;
	endsequence
	sequence s_ack_empty;
		reply_type == (`PCG_REPLY_ACK | `PCG_CMD_SET) && reply_len == `PCG_RLEN_NONE;
	endsequence
	a_set_ack: assert property (s_set_ok |=> s_ack_empty)
		else $error("set command not answered by empty ack");
	a_read_len: assert property (is_read |=> reply_len == `PCG_RLEN_READ && reply_data[31:28] == 4'h0
		&& reply_data[15:11] == 5'h00)
		else $error("read reply length or reserved bits wrong");
	a_bad_index: assert property (go_pulse && !idx_ok && cmd_q.code != `PCG_CMD_STORE |=> reply_type[7:6] == 2'h3)
		else $error("reserved pin index not refused");

	////////////////////////////////////////////////////////////////////////////////
	// per pin logic
	for (genvar i = 0; i < PINS; i++) begin : g_pin
		pcg_pkg::pcg_pad_t pad;
		logic lvl;
		// factory setting of this pin, cut to field width on purpose
		localparam pcg_pkg::pcg_pin_cfg_t FACTORY_CFG = {1'(`PCG_FACTORY_FUNC >> i),
			pcg_pkg::pcg_drive_t'(3'(`PCG_FACTORY_DRIVE >> (3 * i))), 8'h00};

		// configuration; only the low nibble of the config byte is kept
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				cfg_q[i] <= FACTORY_CFG;
			end else if (state == pcg_pkg::ST_RESTORE) begin
				cfg_q[i] <= boot_q[i];
			end else if (is_set && idx == 3'(i)) begin
				cfg_q[i].level <= cmd_q.value;
				if (start_len == `PCG_LEN_SET_CFG) begin
					cfg_q[i].func <= cmd_q.cfg[3];
					cfg_q[i].drive_mode <= pcg_pkg::pcg_drive_t'(cmd_q.cfg[2:0]);
				end
			end
		end

		// boot copy survives soft reset, lost only at power-on
		always_ff @(posedge sys_clk or posedge por) begin
			if (por)
				boot_q[i] <= FACTORY_CFG;
			else if (is_store)
				boot_q[i] <= cfg_q[i];
		end

		// pwm compare, 0 never high, 100 always high
		assign pwm_high[i] = cfg_q[i].level >= `PCG_LEVEL_HIGH || step_cnt < cfg_q[i].level;
		assign lvl = cfg_q[i].func ? pwm_high[i] : role_level[i];

		// drive mode decode
		always_comb begin
			pad = '0;
			unique case (cfg_q[i].drive_mode)
				pcg_pkg::DRV_UP_PULLDN: begin
					pad.drive = lvl;
					pad.pull_dn = !lvl;
				end
				pcg_pkg::DRV_STRONG: pad.drive = 1'b1;
				pcg_pkg::DRV_HIZ: pad = '0;
				pcg_pkg::DRV_PULLUP_DN: begin
					pad.drive = !lvl;
					pad.pull_up = lvl;
				end
				pcg_pkg::DRV_SLOW_UP_HIZ: begin
					pad.drive = lvl;
					pad.slow = 1'b1;
				end
				pcg_pkg::DRV_SLOW: begin
					pad.drive = 1'b1;
					pad.slow = 1'b1;
				end
				pcg_pkg::DRV_RSVD: pad = '0; // reserved code kept safe as an input
				pcg_pkg::DRV_HIZ_SLOW_DN: begin
					pad.drive = !lvl;
					pad.slow = 1'b1;
				end
			endcase
		end

		// registered pad controls
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				gpio_out[i] <= 1'b0;
				gpio_oe_n[i] <= 1'b1;
				gpio_pull_up[i] <= 1'b0;
				gpio_pull_dn[i] <= 1'b0;
				gpio_slow[i] <= 1'b0;
			end else begin
				gpio_out[i] <= lvl;
				gpio_oe_n[i] <= !pad.drive;
				gpio_pull_up[i] <= pad.pull_up;
				gpio_pull_dn[i] <= pad.pull_dn;
				gpio_slow[i] <= pad.slow;
			end
		end

		// pin synchroniser; a change counts once the last two stages agree
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				sync1[i] <= 1'b0;
				sync2[i] <= 1'b0;
				sync3[i] <= 1'b0;
				stab[i] <= 1'b0;
			end else begin
				sync1[i] <= gpio_in[i];
				sync2[i] <= sync1[i];
				sync3[i] <= sync2[i];
				if (sync2[i] == sync3[i])
					stab[i] <= sync3[i];
			end
		end

		// slow sampling is what makes the edge flags bounce free
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				pin_level[i] <= 1'b0;
				rise[i] <= 1'b0;
				fall[i] <= 1'b0;
			end else begin
				if (sample_tick)
					pin_level[i] <= stab[i];
				// a new edge beats a clear in the same cycle
				rise[i] <= (sample_tick && sample_seen && stab[i] && !pin_level[i]) || (rise[i] && !clr[i]);
				fall[i] <= (sample_tick && sample_seen && !stab[i] && pin_level[i]) || (fall[i] && !clr[i]);
			end
		end

		a_level_range: assert property (cfg_q[i].level <= `PCG_LEVEL_HIGH)
			else $error("stored level above 100");
		a_pwm_zero: assert property (cfg_q[i].level == 8'h00 |-> !pwm_high[i])
			else $error("pwm high with level 0");
		a_set_level: assert property (is_set && idx == 3'(i) |=> cfg_q[i].level == $past(cmd_q.value))
			else $error("set command did not store level");
		a_sample_hold: assert property (!sample_tick |=> $stable(pin_level[i]))
			else $error("pin level changed between samples");
		a_rise_flag: assert property (sample_tick && sample_seen && stab[i] && !pin_level[i] |=> rise[i] && pin_level[i])
			else $error("rising edge not flagged");
		a_flag_clear: assert property (clr[i] && !sample_tick |=> !rise[i] && !fall[i])
			else $error("edge flags not cleared by read");
		a_hiz_mode: assert property (cfg_q[i].drive_mode == pcg_pkg::DRV_HIZ |=> gpio_oe_n[i])
			else $error("pin driven in high impedance mode");
		a_default_role: assert property (!cfg_q[i].func |=> gpio_out[i] == $past(role_level[i]))
			else $error("default role level not on pin");
	end

endmodule : pcg_gpio_port

/* pcg_pad_model.sv */
// Purpose: pin load model seen by the gpio port pads
// Assumes: one pad per bit, device drive wins over the bench
// Notes: an undriven pad with no pull toggles so it never looks stable
module pcg_pad_model (
	input wire logic sys_clk,
	input wire logic [4:0] pad_out,
	input wire logic [4:0] oe_n,
	input wire logic [4:0] pull_up,
	input wire logic [4:0] pull_dn,
	input wire logic [4:0] ext_en,
	input wire logic [4:0] ext_val,
	output logic [4:0] pad_lvl
);
	logic flip = 1'b0;
	////////////////////////////////////////////////////////////////////////////////
	// floating pattern, stands in for an unknown level
	always_ff @(posedge sys_clk) begin
		flip <= ~flip;
	end
	// wire level from every party, strongest first
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			if (!oe_n[i])
				pad_lvl[i] = pad_out[i];
			else if (ext_en[i])
				pad_lvl[i] = ext_val[i];
			else if (pull_up[i])
				pad_lvl[i] = 1'b1;
			else if (pull_dn[i])
				pad_lvl[i] = 1'b0;
			else
				pad_lvl[i] = flip;
		end
	end
endmodule : pcg_pad_model

/* tb_top.sv */
// Purpose: self-checking bench of the gpio port
// Assumes: 40 MHz sys_clk, SAMPLE_CYCLES shortened to 64
// Notes: pwm period is 400000 cycles, too long to watch whole here
`include "pcg_defines.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk = 1'b0;
	logic rst, por, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, info, rep;
	logic [1:0] bresp, rresp, resp;
	logic [4:0] pad, gout, oe_n, pu, pd, slw, ext_en, ext_val;
	logic hpc, hrc, ow_tx, hps, ow_rx;
	logic [7:0] idx, val, cfg;
	logic [2:0] px;
	int fails = 0;
	int check_count = 0;
	int seed = 32'h7c4600c6;
	pcg_gpio_port #(.SAMPLE_CYCLES(64)) uut (.sys_clk(sys_clk), .rst(rst), .por(por),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .gpio_in(pad), .gpio_out(gout), .gpio_oe_n(oe_n), .gpio_pull_up(pu),
		.gpio_pull_dn(pd), .gpio_slow(slw), .host_power_ctl(hpc), .host_reset_ctl(hrc),
		.one_wire_sensor_role_tx(ow_tx), .host_power_sense(hps), .one_wire_sensor_role_rx(ow_rx));
	pcg_pad_model pads (.sys_clk(sys_clk), .pad_out(gout), .oe_n(oe_n), .pull_up(pu), .pull_dn(pd),
		.ext_en(ext_en), .ext_val(ext_val), .pad_lvl(pad));
	////////////////////////////////////////////////////////////////////////////////
	// clock and watchdog, the whole run needs well under 30000 cycles
	initial begin
		forever #12.5 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (30000) @(posedge sys_clk);
		fails++;
		wrap_up();
	end
	////////////////////////////////////////////////////////////////////////////////
	// expected pad controls {oe_n, pull_up, pull_dn} for a mode and level
	function automatic logic [2:0] pad_exp(input logic [2:0] m, input logic hi);
		case (m)
			3'h0: return hi ? 3'h0 : 3'h5;
			3'h1, 3'h5: return 3'h0;
			3'h3: return hi ? 3'h6 : 3'h0;
			3'h4: return hi ? 3'h0 : 3'h4;
			3'h7: return hi ? 3'h4 : 3'h0;
			default: return 3'h4;
		endcase
	endfunction : pad_exp
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// bready and rready stay high, so every response is taken on arrival
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge sys_clk);
			if (!aw_done && awready === 1'b1) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready === 1'b1) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge sys_clk); while (bvalid !== 1'b1);
		resp = bresp;
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge sys_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge sys_clk); while (rvalid !== 1'b1);
		d = rdata;
		resp = rresp;
	endtask : axi_rd
	// load, start, then fetch reply info and reply data
	task automatic do_cmd(input logic [7:0] c, input logic [7:0] i, input logic [7:0] v, input logic [7:0] f,
		input logic [1:0] n);
		axi_wr(`PCG_REG_CMD, {f, v, i, c});
		axi_wr(`PCG_REG_GO, {30'h0, n});
		@(posedge sys_clk);
		axi_rd(`PCG_REG_RINFO, info);
		axi_rd(`PCG_REG_REPLY, rep);
	endtask : do_cmd
	task automatic rd_pin(input logic [7:0] i, input logic [7:0] st, input logic [7:0] lv, input logic [7:0] f);
		do_cmd(`PCG_CMD_READ, i, 8'h00, 8'h00, 2'h1);
		chk("read reply info", info[10:0], {3'h4, 8'h63});
		chk("read reply data", rep, {f, lv, st, i});
	endtask : rd_pin
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up
	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		{rst, por, bready, rready} = 4'hF;
		{awvalid, wvalid, arvalid, hpc, hrc, ow_tx} = 6'h00;
		{awaddr, araddr, wdata} = 48'h0;
		ext_en = 5'h01;
		ext_val = 5'h00;
		repeat (8) @(posedge sys_clk);
		chk("oe_n in reset", oe_n, 5'h1F);
		rst <= 1'b0;
		por <= 1'b0;
		repeat (2) @(posedge sys_clk);
		// pin 0 as input: edges between reads, flags cleared by each read
		repeat (200) @(posedge sys_clk);
		rd_pin(8'h00, 8'h00, 8'h00, 8'h02);
		ext_val[0] <= 1'b1;
		repeat (200) @(posedge sys_clk);
		ext_val[0] <= 1'b0;
		repeat (200) @(posedge sys_clk);
		rd_pin(8'h00, 8'h06, 8'h00, 8'h02);
		rd_pin(8'h00, 8'h00, 8'h00, 8'h02);
		ext_val[0] <= 1'b1;
		@(posedge sys_clk);
		ext_val[0] <= 1'b0;
		repeat (200) @(posedge sys_clk);
		rd_pin(8'h00, 8'h00, 8'h00, 8'h02);
		ext_val[0] <= 1'b1;
		repeat (200) @(posedge sys_clk);
		rd_pin(8'h00, 8'h05, 8'h00, 8'h02);
		axi_rd(`PCG_REG_PINS, rep);
		chk("pins pin 0", {rep[10], rep[5], rep[0]}, 3'h1);
		$display("test edges done");
		// refused requests leave an error reply
		do_cmd(`PCG_CMD_SET, 8'h05, 8'h00, 8'h00, 2'h2);
		chk("bad index type", info[7:0], 8'hE2);
		do_cmd(`PCG_CMD_SET, 8'h00, 8'h65, 8'h00, 2'h2);
		chk("bad value type", info[7:0], 8'hE2);
		axi_rd(8'h20, rep);
		chk("unmapped resp", {30'h0, resp}, {30'h0, `PCG_RESP_SLVERR});
		chk("unmapped data", rep, 32'h0);
		axi_wr(8'h20, 32'h0);
		chk("unmapped write resp", {30'h0, resp}, {30'h0, `PCG_RESP_SLVERR});
		$display("test refusals done");
		// every drive mode at both static levels, user control
		for (int m = 0; m < 16; m++) begin
			do_cmd(`PCG_CMD_SET, 8'h00, m[0] ? 8'h64 : 8'h00, {5'h01, m[3:1]}, 2'h3);
			chk("set reply", info[10:0], {3'h0, 8'h62});
			px = pad_exp(m[3:1], m[0]);
			chk("pad controls", {oe_n[0], pu[0], pd[0]}, px);
			if (!px[2]) begin
				chk("pad level", gout[0], m[0]);
				chk("pad slow", slw[0], m[3:1] inside {3'h4, 3'h5, 3'h7});
			end
		end
		$display("test drive modes done");
		// default roles of pins 1 to 4
		do_cmd(`PCG_CMD_SET, 8'h02, 8'h00, 8'h01, 2'h3);
		do_cmd(`PCG_CMD_SET, 8'h03, 8'h00, 8'h01, 2'h3);
		hpc <= 1'b1;
		hrc <= 1'($random(seed));
		repeat (3) @(posedge sys_clk);
		chk("power ctl high", {oe_n[2], gout[2]}, 2'h1);
		chk("reset ctl", {oe_n[3], gout[3]}, {1'b0, hrc});
		hpc <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk("power ctl low", {oe_n[2], gout[2]}, 2'h0);
		ow_tx <= 1'b1;
		ext_en[4] <= 1'b1;
		ext_val[4] <= 1'b1;
		ext_en[1] <= 1'b1;
		ext_val[1] <= 1'b1;
		repeat (200) @(posedge sys_clk);
		chk("one wire rx", ow_rx, 1'b1);
		chk("one wire tx", {oe_n[4], gout[4]}, 2'h3);
		chk("power sense", hps, 1'b1);
		$display("test roles done");
		// random set and read back, value only sets keep the configuration
		for (int k = 0; k < 6; k++) begin
			idx = 8'($unsigned($random(seed)) % 5);
			val = 8'($unsigned($random(seed)) % 101);
			cfg = 8'($unsigned($random(seed)) % 16);
			ow_tx <= 1'($random(seed));
			do_cmd(`PCG_CMD_SET, idx, val, cfg, 2'h3);
			val = 8'($unsigned($random(seed)) % 101);
			do_cmd(`PCG_CMD_SET, idx, val, 8'hF0, 2'h2);
			do_cmd(`PCG_CMD_READ, idx, 8'h00, 8'h00, 2'h1);
			chk("readback", {rep[31:16], rep[7:0]}, {cfg, val, idx});
		end
		$display("test random done");
		// stored configuration comes back after a soft reset
		do_cmd(`PCG_CMD_SET, 8'h00, 8'h21, 8'h0D, 2'h3);
		do_cmd(`PCG_CMD_STORE, 8'h00, 8'h00, 8'h00, 2'h0);
		chk("store reply", info[10:0], {3'h0, 8'h44});
		do_cmd(`PCG_CMD_SET, 8'h00, 8'h07, 8'h00, 2'h2);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		do_cmd(`PCG_CMD_READ, 8'h00, 8'h00, 8'h00, 2'h1);
		chk("restored", {rep[31:16], rep[7:0]}, 24'h0D2100);
		$display("test store done");
		wrap_up();
	end
endmodule : tb_top
